// *** design/droop_detect_ctrl.sv ***
// Supply droop detector control and reset cause flags
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
// How it works
// R1: Software reads the reset cause flags only as a whole byte.
// R2: A power-on-clear reset sets every reset cause flag to zero.
// R3: A byte write of zero to the mode register stops detection.
// R4: Clearing the enable bit alone also stops detection.
// R5: Software writes zero to bits 2 to 6 of the mode register.
// R6: Software writes zero to bits 4 to 7 of the level select register.
// R7: Writing the level select register while running leaves it undefined.
// R8: Software stops the detector before changing the level select register.
// R9: In reset mode no internal reset is raised while the supply is above the level.
// R10: The detector's own internal reset never resets the detector registers.
// R11: Writes take effect on the next clock edge and reads have no side effects.
module droop_detect_ctrl
    import droop_pkg::*;
(
    // Clock and resets
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       poc_reset_in,
    input  wire logic       other_reset_in,
    // Comparator
    input  wire logic       supply_low_in,
    // Register port
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Detector outputs
    output logic            droop_reset_out,
    output logic            droop_flag_out,
    output logic            detect_run_out,
    output logic      [3:0] level_sel_out
);
    // ----------------------------------------
    // Address match, shared by write and read decode
    // ----------------------------------------
    function automatic logic addr_hit(input logic [1:0] addr, input logic [1:0] off);
        return addr == off;
    endfunction : addr_hit

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] cause_reg;
    logic [7:0] rdata_reg;
    logic       reset_reg;
    logic       flag_reg;
    logic [7:0] level_w;
    logic       run_reg;
    logic [3:0] lvl_reg;

    wire wr_mode  = wr_in && addr_hit(addr_in, OFF_MODE_CONTROL);
    wire wr_level = wr_in && addr_hit(addr_in, OFF_LEVEL_SELECT);
    wire running  = mode_reg[ENABLE_BIT];
    // A zero byte clears enable too, which stops detection
    wire [7:0] mode_next = wdata_in & MODE_WR_MASK; // see R3 see R4
    wire droop_hit  = running && supply_low_in;
    wire reset_next = droop_hit && mode_reg[RESET_MODE_BIT]; // see R9
    wire flag_next  = droop_hit && !mode_reg[RESET_MODE_BIT];

    // ----------------------------------------
    // Mode register: only rst_in, not own droop reset
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            mode_reg <= MODE_RESET_VAL; // see R10
        else if (wr_mode)
            mode_reg <= mode_next; // see R11
    end

    droop_level_reg droop_level_reg_inst (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .wr_in      (wr_level),
        .wdata_in   (wdata_in),
        .running_in (running),
        .level_out  (level_w)
    );

    // ----------------------------------------
    // Reset cause flags: power-on-clear wipes them
    // ----------------------------------------
    // Clear beats a same-cycle set, the power-on-clear being a reset itself
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            cause_reg <= CAUSE_CLEAR_VAL;
        else if (poc_reset_in)
            cause_reg <= CAUSE_CLEAR_VAL; // see R2
        else
        begin
            if (reset_reg)
                cause_reg[CAUSE_DROOP] <= 1'b1;
            if (other_reset_in)
                cause_reg[CAUSE_OTHER] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Detector outputs
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reset_reg <= 1'b0;
            flag_reg  <= 1'b0;
        end
        else
        begin
            reset_reg <= reset_next; // see R9
            flag_reg  <= flag_next;
        end
    end

    // ----------------------------------------
    // Read port, side-effect free, whole bytes
    // ----------------------------------------
    wire [7:0] rd_mux = addr_hit(addr_in, OFF_RESET_CAUSE)  ? cause_reg :
                        addr_hit(addr_in, OFF_MODE_CONTROL) ? mode_reg  :
                        addr_hit(addr_in, OFF_LEVEL_SELECT) ? level_w   :
                        {7'h00, reset_reg | flag_reg};

    // Idle read data is zero so a stale byte never looks fresh

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_reg <= 8'h00;
        else if (rd_in)
            rdata_reg <= rd_mux; // see R1 see R11
        else
            rdata_reg <= 8'h00;
    end

    // ----------------------------------------
    // Output copies, on the same edge as the registers they mirror
    // ----------------------------------------
    wire       run_next = wr_mode ? mode_next[ENABLE_BIT] : running;
    wire [3:0] lvl_next = wr_level ? (running ? LEVEL_UNDEF_VAL[3:0] : wdata_in[3:0])
                                   : level_w[3:0];

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            run_reg <= 1'b0;
        else
            run_reg <= run_next; // see R3 see R4
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            lvl_reg <= 4'h0;
        else
            lvl_reg <= lvl_next; // see R7
    end

    assign rdata_out       = rdata_reg;
    assign droop_reset_out = reset_reg;
    assign droop_flag_out  = flag_reg;
    assign detect_run_out  = run_reg;
    assign level_sel_out   = lvl_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_poc_clears_flags: assert property (@(posedge mclk_in) disable iff (rst_in) // see R2
        poc_reset_in |=> (cause_reg == 8'h00))
        else $error("cause flags not cleared by power-on-clear");
    chk_zero_write_stops: assert property (@(posedge mclk_in) disable iff (rst_in) // see R3
        (wr_mode && wdata_in == 8'h00) |=> !running ##1 !reset_reg && !flag_reg)
        else $error("zero mode write did not stop detector");
    chk_enable_clear_stops: assert property (@(posedge mclk_in) disable iff (rst_in) // see R4
        (wr_mode && !wdata_in[ENABLE_BIT]) |=> !detect_run_out)
        else $error("enable clear did not stop detector");
    chk_no_reset_above: assert property (@(posedge mclk_in) disable iff (rst_in) // see R9
        !supply_low_in |=> !droop_reset_out)
        else $error("droop reset raised with supply above level");
    chk_own_reset_keeps: assert property (@(posedge mclk_in) disable iff (rst_in) // see R10
        (reset_reg && !wr_mode) |=> $stable(mode_reg))
        else $error("droop reset disturbed mode register");
    chk_read_one_cycle: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        (rd_in && addr_in == OFF_MODE_CONTROL && !wr_in) |=> (rdata_out == $past(mode_reg)))
        else $error("read data wrong in cycle after strobe");
    chk_write_next_edge: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        wr_mode |=> (mode_reg == $past(wdata_in & MODE_WR_MASK)))
        else $error("mode write not taken on next edge");

    // ----------------------------------------
    // Checks on outputs, the read port and register writes
    // ----------------------------------------
    chk_flag_mode_quiet: assert property (@(posedge mclk_in) disable iff (rst_in) // see R9
        !mode_reg[RESET_MODE_BIT] |=> !droop_reset_out)
        else $error("droop reset raised in flag mode");
    chk_stopped_no_output: assert property (@(posedge mclk_in) disable iff (rst_in) // see R4
        !running |=> (!droop_reset_out && !droop_flag_out))
        else $error("detector output raised while stopped");
    chk_run_mirror: assert property (@(posedge mclk_in) disable iff (rst_in) // see R4
        detect_run_out == running)
        else $error("run output differs from enable bit");
    chk_level_out_mirror: assert property (@(posedge mclk_in) disable iff (rst_in) // see R7
        level_sel_out == level_w[3:0])
        else $error("level output differs from level register");
    chk_read_cause_byte: assert property (@(posedge mclk_in) disable iff (rst_in) // see R1
        (rd_in && addr_in == OFF_RESET_CAUSE) |=> (rdata_out == $past(cause_reg)))
        else $error("cause read did not return the whole byte");
    chk_read_no_effect: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        (rd_in && !wr_in && !poc_reset_in && !other_reset_in && !reset_reg)
            |=> ($stable(cause_reg) && $stable(mode_reg) && $stable(level_w)))
        else $error("read disturbed a register");
    chk_rdata_idle_zero: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        !rd_in |=> (rdata_out == 8'h00))
        else $error("read data not zero outside a read");
    chk_level_stopped_write: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        (wr_level && !running) |=> (level_w == $past(wdata_in & LEVEL_WR_MASK)))
        else $error("level write while stopped not taken");
    chk_status_write_ignored: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
        (wr_in && addr_in == OFF_DETECT_STATUS) |=> ($stable(mode_reg) && $stable(level_w)))
        else $error("write to status index changed a register");
endmodule : droop_detect_ctrl
`default_nettype wire

// *** design/droop_pkg.sv ***
// Package with register map, field positions and reset values of the droop detector block
`default_nettype none
package droop_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [1:0] OFF_RESET_CAUSE   = 2'h0;
    localparam logic [1:0] OFF_MODE_CONTROL  = 2'h1;
    localparam logic [1:0] OFF_LEVEL_SELECT  = 2'h2;
    localparam logic [1:0] OFF_DETECT_STATUS = 2'h3;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ENABLE_BIT     = 7;
    localparam int RESET_MODE_BIT = 1;
    localparam int FLAG_MODE_BIT  = 0;
    localparam int CAUSE_DROOP    = 0;
    localparam int CAUSE_OTHER    = 1;
    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET_VAL  = 8'h00;
    localparam logic [7:0] LEVEL_RESET_VAL = 8'h00;
    localparam logic [7:0] CAUSE_CLEAR_VAL = 8'h00;
    localparam logic [7:0] MODE_WR_MASK    = 8'h83;
    localparam logic [7:0] LEVEL_WR_MASK   = 8'h0f;
    localparam logic [7:0] LEVEL_UNDEF_VAL = 8'h0f;
endpackage : droop_pkg
`default_nettype wire

// *** design/droop_level_reg.sv ***
// Detection level select register with running-write corruption
`default_nettype none
module droop_level_reg
    import droop_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // Write port
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       running_in,
    // Level out
    output logic      [7:0] level_out
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] level_reg;
    wire  [7:0] level_next = running_in ? LEVEL_UNDEF_VAL : (wdata_in & LEVEL_WR_MASK);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            level_reg <= LEVEL_RESET_VAL;
        else if (wr_in)
            level_reg <= level_next; // see R7 see R11
    end

    assign level_out = level_reg;

    chk_level_running_write: assert property (@(posedge mclk_in) disable iff (rst_in) // see R7
        (wr_in && running_in) |=> (level_reg == LEVEL_UNDEF_VAL))
        else $error("level write while running not corrupted");
endmodule : droop_level_reg
`default_nettype wire

// *** verification/low_voltage_detect_reset_flags_tb.sv ***
// Testbench for the droop detector control and reset cause flags
`default_nettype none
module low_voltage_detect_reset_flags_tb
    import droop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk_in, rst_in, poc_reset_in, other_reset_in, supply_low_in;
    logic       wr_in, rd_in, droop_reset_out, droop_flag_out, detect_run_out;
    logic [1:0] addr_in;
    logic [7:0] wdata_in, rdata_out;
    logic [3:0] level_sel_out;
    int         bad_count, num_checks;
    droop_detect_ctrl droop_detect_ctrl_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .poc_reset_in(poc_reset_in), .other_reset_in(other_reset_in),
        .supply_low_in(supply_low_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .droop_reset_out(droop_reset_out), .droop_flag_out(droop_flag_out),
        .detect_run_out(detect_run_out), .level_sel_out(level_sel_out));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        tick(1);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        tick(1);
        rd_in <= 1'b0;
        chk(what, rdata_out, exp);
    endtask : rdchk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // Clock, hang guard and tests
    // ----------------------------------------
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    initial
    begin
        repeat (5000) @(posedge mclk_in);
        bad_count++;
        conclude();
    end
    initial
    begin
        {rst_in, poc_reset_in, other_reset_in, supply_low_in, wr_in, rd_in} = 6'h20;
        addr_in  = 2'h0;
        wdata_in = 8'h00;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rdchk(OFF_RESET_CAUSE, CAUSE_CLEAR_VAL, "cause");
        rdchk(OFF_MODE_CONTROL, MODE_RESET_VAL, "mode");
        rdchk(OFF_LEVEL_SELECT, LEVEL_RESET_VAL, "level");
        $display("test reset done");
        wr(OFF_LEVEL_SELECT, 8'h05);
        rdchk(OFF_LEVEL_SELECT, 8'h05, "level");
        chk("level_sel", level_sel_out, 8'h05);
        wr(OFF_MODE_CONTROL, 8'h83);
        chk("run", detect_run_out, 8'h01);
        rdchk(OFF_MODE_CONTROL, 8'h83, "mode");
        wr(OFF_LEVEL_SELECT, 8'h03);
        rdchk(OFF_LEVEL_SELECT, LEVEL_UNDEF_VAL, "level");
        tick(3);
        chk("droop_reset", droop_reset_out, 8'h00);
        supply_low_in <= 1'b1;
        tick(3);
        chk("droop_reset", droop_reset_out, 8'h01);
        supply_low_in <= 1'b0;
        tick(3);
        chk("droop_reset", droop_reset_out, 8'h00);
        rdchk(OFF_MODE_CONTROL, 8'h83, "mode");
        rdchk(OFF_RESET_CAUSE, 8'h01, "cause");
        rdchk(OFF_RESET_CAUSE, 8'h01, "cause");
        $display("test reset mode done");
        wr(OFF_MODE_CONTROL, 8'h00);
        chk("run", detect_run_out, 8'h00);
        supply_low_in <= 1'b1;
        tick(3);
        chk("droop_reset", droop_reset_out, 8'h00);
        wr(OFF_MODE_CONTROL, 8'h81);
        tick(3);
        chk("droop_flag", droop_flag_out, 8'h01);
        chk("droop_reset", droop_reset_out, 8'h00);
        rdchk(OFF_DETECT_STATUS, 8'h01, "status");
        wr(OFF_MODE_CONTROL, 8'h01);
        tick(3);
        chk("run", detect_run_out, 8'h00);
        chk("droop_flag", droop_flag_out, 8'h00);
        supply_low_in <= 1'b0;
        rdchk(OFF_DETECT_STATUS, 8'h00, "status");
        wr(OFF_LEVEL_SELECT, 8'h05);
        rdchk(OFF_LEVEL_SELECT, 8'h05, "level");
        chk("level_sel", level_sel_out, 8'h05);
        $display("test stop done");
        other_reset_in <= 1'b1;
        tick(1);
        other_reset_in <= 1'b0;
        rdchk(OFF_RESET_CAUSE, 8'h03, "cause");
        wr(OFF_RESET_CAUSE, 8'h00);
        wr(OFF_DETECT_STATUS, 8'h00);
        rdchk(OFF_MODE_CONTROL, 8'h01, "mode");
        rdchk(OFF_RESET_CAUSE, 8'h03, "cause");
        poc_reset_in   <= 1'b1;
        other_reset_in <= 1'b1;
        tick(1);
        {poc_reset_in, other_reset_in} <= 2'h0;
        rdchk(OFF_RESET_CAUSE, CAUSE_CLEAR_VAL, "cause");
        $display("test cause flags done");
        conclude();
    end
endmodule : low_voltage_detect_reset_flags_tb
`default_nettype wire
